// ---- logic/legacy_activity_smi_monitor.sv ----
// Purpose: legacy activity monitor with I/O monitor ranges and cycle trackers
// Assumes: one observed I/O cycle per valid pulse; register port offsets in bytes
// Notes: outputs are registered; read data appears one clock after the read
//
// Behaviour
// RQ1 - a management interrupt from a range-two access sets status bit 13, and writing one clears it.
// RQ2 - a management interrupt from a range-one access sets status bit 12, and writing one clears it.
// RQ3 - enable bit 9 lets range-two accesses raise the management interrupt, otherwise they do not.
// RQ4 - enable bit 8 lets range-one accesses raise the management interrupt, otherwise they do not.
// RQ5 - activity bits other than 6 to 9 set when an I/O access hits their device's range.
// RQ6 - activity bits 6 to 9 report PCI interrupt lines A to D while those lines are active.
// RQ7 - each activity bit stays set until software writes one to it; zero leaves it alone.
// RQ8 - bit 13 music synth, 12 keyboard 60h/64h, 11 music port, 10 sound, 5 legacy ports.
// RQ9 - bits 0 to 3 flag primary drive 0, primary drive 1, secondary 0, secondary 1; bit 4 reserved.
// RQ10 - on interrupt assertion the low 16 address bits of the last I/O cycle are captured.
// RQ11 - on interrupt assertion byte enables go to bits 7:4 and cycle type to bits 3:0.
// RQ12 - the summary flag is a plain OR of bits 12 and 13 of both status registers.
// RQ13 - range base and length come from outside and are decoded per observed cycle.
`timescale 1ns/1ps
module legacy_activity_smi_monitor (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire activity_monitor_pkg::io_cycle_s io_cycle_in,
	input wire logic [3:0] pci_int_n_in,
	input wire activity_monitor_pkg::range_cfg_s [1:0] range_cfg_in,
	input wire activity_monitor_pkg::reg_req_s reg_req_in,
	output logic [15:0] reg_rdata_out,
	output logic reg_rvalid_out,
	output logic mgmt_interrupt_n_out,
	output logic device_monitor_summary_out
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] mon_en;
		logic [1:0] mon_flag;
		logic [15:0] activity;
		logic [15:0] addr_track;
		logic [7:0] cyc_track;
		logic [15:0] last_addr;
		logic [3:0] last_be;
		logic [3:0] last_cmd;
		logic [1:0] drive_sel;
		logic smi;
		logic [15:0] rdata;
		logic rvalid;
		logic summary;
	} state_s;

	state_s st_reg;
	state_s st_next;

	function automatic logic in_win(input logic [15:0] a, input logic [15:0] lo,
			input logic [15:0] hi);
		in_win = (a >= lo) && (a <= hi);
	endfunction : in_win

	// ----------------------------------------------------------------
	// programmable range decode
	// ----------------------------------------------------------------
	logic [1:0] range_hit;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_range
			io_range_match #(
				.WIDTH(16)
			) u_match (
				.addr_in(io_cycle_in.addr),
				.base_in(range_cfg_in[gi].base),
				.len_in(range_cfg_in[gi].len),
				.hit_out(range_hit[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic [15:0] act_set;
	logic [15:0] act_clr;
	logic [15:0] wmask;
	logic [1:0] mon_set;
	logic [1:0] mon_clr;
	logic [15:0] a;
	logic pri_hit;
	logic sec_hit;
	logic smi_next;

	always_comb begin
		st_next = st_reg;
		a = io_cycle_in.addr;
		wmask = {{8{reg_req_in.be[1]}}, {8{reg_req_in.be[0]}}};
		act_set = 16'h0000;
		act_clr = 16'h0000;
		mon_clr = 2'b00;

		// drive select tracking lets a channel access be charged to one drive
		if (io_cycle_in.valid && io_cycle_in.cmd == activity_monitor_pkg::CMD_IO_WRITE) begin
			if (a == activity_monitor_pkg::IDE_PRI_SEL) begin
				st_next.drive_sel[0] = io_cycle_in.data[activity_monitor_pkg::DRIVE_SEL_BIT];
			end
			if (a == activity_monitor_pkg::IDE_SEC_SEL) begin
				st_next.drive_sel[1] = io_cycle_in.data[activity_monitor_pkg::DRIVE_SEL_BIT];
			end
		end

		pri_hit = in_win(a, activity_monitor_pkg::IDE_PRI_LO, activity_monitor_pkg::IDE_PRI_HI)
			|| a == activity_monitor_pkg::IDE_PRI_CTL;
		sec_hit = in_win(a, activity_monitor_pkg::IDE_SEC_LO, activity_monitor_pkg::IDE_SEC_HI)
			|| a == activity_monitor_pkg::IDE_SEC_CTL;

		if (io_cycle_in.valid) begin
			act_set[activity_monitor_pkg::BIT_MUSIC_SYNTH] = in_win(a, // see RQ8
				activity_monitor_pkg::SYNTH_LO, activity_monitor_pkg::SYNTH_HI);
			act_set[activity_monitor_pkg::BIT_KEYBOARD] = a == activity_monitor_pkg::KBC_DATA
				|| a == activity_monitor_pkg::KBC_CMD; // see RQ8
			act_set[activity_monitor_pkg::BIT_MUSIC_PORT] = in_win(a,
				activity_monitor_pkg::MIDI_LO, activity_monitor_pkg::MIDI_HI); // see RQ8
			act_set[activity_monitor_pkg::BIT_SOUND] = in_win(a, // see RQ8
				activity_monitor_pkg::SND_A_LO, activity_monitor_pkg::SND_A_HI)
				|| in_win(a, activity_monitor_pkg::SND_B_LO, activity_monitor_pkg::SND_B_HI);
			act_set[activity_monitor_pkg::BIT_LEGACY_PORT] = // see RQ8
				in_win(a, activity_monitor_pkg::LPT_LO, activity_monitor_pkg::LPT_HI)
				|| in_win(a, activity_monitor_pkg::COM1_LO, activity_monitor_pkg::COM1_HI)
				|| in_win(a, activity_monitor_pkg::COM2_LO, activity_monitor_pkg::COM2_HI)
				|| in_win(a, activity_monitor_pkg::FDC_LO, activity_monitor_pkg::FDC_HI)
				|| a == activity_monitor_pkg::FDC_DIR;
			act_set[activity_monitor_pkg::BIT_PRI_DRIVE0] = pri_hit && !st_next.drive_sel[0]; // see RQ9
			act_set[activity_monitor_pkg::BIT_PRI_DRIVE1] = pri_hit && st_next.drive_sel[0]; // see RQ9
			act_set[activity_monitor_pkg::BIT_SEC_DRIVE0] = sec_hit && !st_next.drive_sel[1]; // see RQ9
			act_set[activity_monitor_pkg::BIT_SEC_DRIVE1] = sec_hit && st_next.drive_sel[1]; // see RQ9
		end
		// interrupt lines are active low; bit sets while the line is asserted and stays set after release
		act_set[activity_monitor_pkg::BIT_PCI_INT_A +: 4] = ~pci_int_n_in; // see RQ6

		// a hit sets its flag only when its enable lets it raise the interrupt
		mon_set = {io_cycle_in.valid && range_hit[1] && st_reg.mon_en[1], // see RQ3
			io_cycle_in.valid && range_hit[0] && st_reg.mon_en[0]}; // see RQ4

		if (reg_req_in.wr) begin
			if (reg_req_in.addr == activity_monitor_pkg::OFS_MON_STS_EN) begin
				mon_clr = reg_req_in.wdata[activity_monitor_pkg::BIT_RANGE_TWO_FLAG -: 2]
					& {2{reg_req_in.be[1]}}; // see RQ1
				if (reg_req_in.be[1]) begin
					st_next.mon_en = reg_req_in.wdata[activity_monitor_pkg::BIT_RANGE_TWO_EN -: 2];
				end
			end
			if (reg_req_in.addr == activity_monitor_pkg::OFS_DEV_ACT) begin
				act_clr = reg_req_in.wdata & wmask; // see RQ7
			end
		end

		// set wins over a clear landing in the same cycle
		st_next.mon_flag = (st_reg.mon_flag & ~mon_clr) | mon_set; // see RQ1, RQ2
		st_next.activity = ((st_reg.activity & ~act_clr) | act_set)
			& activity_monitor_pkg::ACT_IMPL_MASK; // see RQ5

		smi_next = |st_next.mon_flag; // see RQ2
		st_next.smi = smi_next;
		// capture on the assertion edge; the current cycle counts as most recent
		if (smi_next && !st_reg.smi) begin
			st_next.addr_track = io_cycle_in.valid ? io_cycle_in.addr : st_reg.last_addr; // see RQ10
			st_next.cyc_track = io_cycle_in.valid ? {io_cycle_in.be, io_cycle_in.cmd}
				: {st_reg.last_be, st_reg.last_cmd}; // see RQ11
		end
		if (io_cycle_in.valid) begin
			st_next.last_addr = io_cycle_in.addr;
			st_next.last_be = io_cycle_in.be;
			st_next.last_cmd = io_cycle_in.cmd;
		end

		st_next.summary = (|st_reg.mon_flag) // see RQ12
			|| st_reg.activity[activity_monitor_pkg::BIT_KEYBOARD]
			|| st_reg.activity[activity_monitor_pkg::BIT_MUSIC_SYNTH];

		st_next.rvalid = reg_req_in.rd;
		st_next.rdata = 16'h0000;
		if (reg_req_in.rd) begin
			unique case (reg_req_in.addr)
				activity_monitor_pkg::OFS_MON_STS_EN: begin
					st_next.rdata = {2'b00, st_reg.mon_flag, 2'b00, st_reg.mon_en, 8'h00};
				end
				activity_monitor_pkg::OFS_DEV_ACT: begin
					st_next.rdata = st_reg.activity;
				end
				activity_monitor_pkg::OFS_ADDR_TRACK: begin
					st_next.rdata = st_reg.addr_track;
				end
				activity_monitor_pkg::OFS_CYC_TRACK: begin
					st_next.rdata = {8'h00, st_reg.cyc_track};
				end
				default: begin
					st_next.rdata = 16'h0000;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			st_reg <= '0;
			st_reg.mon_en <= activity_monitor_pkg::RST_MON_STS_EN[9:8];
			st_reg.activity <= activity_monitor_pkg::RST_DEV_ACT;
			st_reg.addr_track <= activity_monitor_pkg::RST_TRACK;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata_out = st_reg.rdata;
	assign reg_rvalid_out = st_reg.rvalid;
	assign mgmt_interrupt_n_out = ~st_reg.smi;
	assign device_monitor_summary_out = st_reg.summary;

endmodule : legacy_activity_smi_monitor

// ---- logic/activity_monitor_pkg.sv ----
// Purpose: shared constants and carriers for the legacy activity monitor
// Assumes: register offsets are byte offsets from the power management I/O base
// Notes: fixed legacy decode windows are inclusive low/high byte addresses
package activity_monitor_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_MON_STS_EN = 8'h40;
	localparam logic [7:0] OFS_DEV_ACT = 8'h44;
	localparam logic [7:0] OFS_ADDR_TRACK = 8'h4c;
	localparam logic [7:0] OFS_CYC_TRACK = 8'h4e;
	localparam logic [15:0] RST_MON_STS_EN = 16'h0000;
	localparam logic [15:0] RST_DEV_ACT = 16'h0000;
	localparam logic [15:0] RST_TRACK = 16'h0000;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_RANGE_TWO_FLAG = 13;
	localparam int BIT_RANGE_ONE_FLAG = 12;
	localparam int BIT_RANGE_TWO_EN = 9;
	localparam int BIT_RANGE_ONE_EN = 8;
	localparam int BIT_MUSIC_SYNTH = 13;
	localparam int BIT_KEYBOARD = 12;
	localparam int BIT_MUSIC_PORT = 11;
	localparam int BIT_SOUND = 10;
	localparam int BIT_PCI_INT_A = 6;
	localparam int BIT_LEGACY_PORT = 5;
	localparam int BIT_PRI_DRIVE0 = 0;
	localparam int BIT_PRI_DRIVE1 = 1;
	localparam int BIT_SEC_DRIVE0 = 2;
	localparam int BIT_SEC_DRIVE1 = 3;
	localparam logic [15:0] ACT_IMPL_MASK = 16'h3fef;
	localparam int DRIVE_SEL_BIT = 4;
	localparam logic [3:0] CMD_IO_WRITE = 4'h3;

	// ----------------------------------------------------------------
	// fixed legacy decode windows
	// ----------------------------------------------------------------
	localparam logic [15:0] KBC_DATA = 16'h0060;
	localparam logic [15:0] KBC_CMD = 16'h0064;
	localparam logic [15:0] SYNTH_LO = 16'h0388;
	localparam logic [15:0] SYNTH_HI = 16'h038b;
	localparam logic [15:0] MIDI_LO = 16'h0330;
	localparam logic [15:0] MIDI_HI = 16'h0331;
	localparam logic [15:0] SND_A_LO = 16'h0220;
	localparam logic [15:0] SND_A_HI = 16'h0233;
	localparam logic [15:0] SND_B_LO = 16'h0530;
	localparam logic [15:0] SND_B_HI = 16'h0537;
	localparam logic [15:0] LPT_LO = 16'h0378;
	localparam logic [15:0] LPT_HI = 16'h037f;
	localparam logic [15:0] COM1_LO = 16'h03f8;
	localparam logic [15:0] COM1_HI = 16'h03ff;
	localparam logic [15:0] COM2_LO = 16'h02f8;
	localparam logic [15:0] COM2_HI = 16'h02ff;
	localparam logic [15:0] FDC_LO = 16'h03f0;
	localparam logic [15:0] FDC_HI = 16'h03f5;
	localparam logic [15:0] FDC_DIR = 16'h03f7;
	localparam logic [15:0] IDE_PRI_LO = 16'h01f0;
	localparam logic [15:0] IDE_PRI_HI = 16'h01f7;
	localparam logic [15:0] IDE_PRI_CTL = 16'h03f6;
	localparam logic [15:0] IDE_PRI_SEL = 16'h01f6;
	localparam logic [15:0] IDE_SEC_LO = 16'h0170;
	localparam logic [15:0] IDE_SEC_HI = 16'h0177;
	localparam logic [15:0] IDE_SEC_CTL = 16'h0376;
	localparam logic [15:0] IDE_SEC_SEL = 16'h0176;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic [15:0] addr;
		logic [3:0] be;
		logic [3:0] cmd;
		logic [7:0] data;
	} io_cycle_s;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [1:0] be;
		logic [15:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic [15:0] base;
		logic [15:0] len;
	} range_cfg_s;

endpackage : activity_monitor_pkg

// ---- logic/io_range_match.sv ----
// Purpose: combinational hit test of an address against base and length
// Assumes: a length of zero never matches
// Notes: base plus length may wrap past the top of the space
`timescale 1ns/1ps
module io_range_match #(
	parameter int WIDTH = 16
) (
	input wire logic [WIDTH-1:0] addr_in,
	input wire logic [WIDTH-1:0] base_in,
	input wire logic [WIDTH-1:0] len_in,
	output logic hit_out
);

	// refused at elaboration, before any logic is built
	if (WIDTH < 1) begin : g_bad_width
		$error("io_range_match: WIDTH must be at least one");
	end

	logic [WIDTH-1:0] offset;

	// offset compare avoids a wide adder overflow on the upper bound
	always_comb begin
		offset = WIDTH'(addr_in - base_in);
		hit_out = (addr_in >= base_in) && (offset < len_in); // see RQ13
	end

endmodule : io_range_match

// ---- verification/activity_monitor_asserts.sv ----
// Purpose: port checks for the legacy activity monitor
// Assumes: one clock, synchronous reset; range enables shadowed from register writes
// Notes: the shadow ignores reads, so a read-back slip cannot hide an enable slip
`timescale 1ns/1ps
module activity_monitor_asserts (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire activity_monitor_pkg::io_cycle_s io_cycle_in,
	input wire logic [3:0] pci_int_n_in,
	input wire activity_monitor_pkg::range_cfg_s [1:0] range_cfg_in,
	input wire activity_monitor_pkg::reg_req_s reg_req_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic reg_rvalid_out,
	input wire logic mgmt_interrupt_n_out,
	input wire logic device_monitor_summary_out
);
	logic [1:0] en_reg;
	logic [1:0] hit;
	logic cause;
	logic clr;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			en_reg <= 2'h0;
		end else if (reg_req_in.wr && reg_req_in.addr == 8'h40 && reg_req_in.be[1]) begin
			en_reg <= reg_req_in.wdata[9:8];
		end
	end
	// 17-bit sum so a range ending at the top of the space never wraps into a miss
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			hit[i] = io_cycle_in.valid && io_cycle_in.addr >= range_cfg_in[i].base
				&& {1'b0, io_cycle_in.addr} < {1'b0, range_cfg_in[i].base} + {1'b0, range_cfg_in[i].len};
		end
	end
	assign cause = |(hit & en_reg);
	assign clr = reg_req_in.wr && reg_req_in.addr == 8'h40 && reg_req_in.be[1]
		&& |reg_req_in.wdata[13:12];
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	sequence s_rd(logic [7:0] a);
		reg_req_in.rd && reg_req_in.addr == a;
	endsequence
	property p_rvalid;
		reg_rvalid_out == $past(reg_req_in.rd);
	endproperty
	property p_rdata_idle;
		!reg_rvalid_out |-> reg_rdata_out == 16'h0;
	endproperty
	property p_sts_rsvd;
		s_rd(8'h40) |=> (reg_rdata_out & 16'hccff) == 16'h0;
	endproperty
	property p_act_rsvd;
		s_rd(8'h44) |=> (reg_rdata_out & 16'hc010) == 16'h0;
	endproperty
	property p_hit_irq;
		cause |=> !mgmt_interrupt_n_out;
	endproperty
	property p_irq_cause;
		$fell(mgmt_interrupt_n_out) |-> $past(cause);
	endproperty
	property p_irq_clear;
		$rose(mgmt_interrupt_n_out) |-> $past(clr);
	endproperty
	property p_summary;
		!mgmt_interrupt_n_out |=> device_monitor_summary_out;
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read answer timing off");
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
	a_sts_rsvd: assert property (p_sts_rsvd) else $error("reserved status bits read one");
	a_act_rsvd: assert property (p_act_rsvd) else $error("reserved activity bit set");
	a_hit_irq: assert property (p_hit_irq) else $error("enabled hit gave no interrupt");
	a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");
	a_irq_clear: assert property (p_irq_clear) else $error("interrupt left without clear");
	a_summary: assert property (p_summary) else $error("summary missing");
endmodule : activity_monitor_asserts

bind legacy_activity_smi_monitor activity_monitor_asserts chk_u (.clk_in(clk_in),
	.srst_in(srst_in), .io_cycle_in(io_cycle_in), .pci_int_n_in(pci_int_n_in),
	.range_cfg_in(range_cfg_in), .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out),
	.reg_rvalid_out(reg_rvalid_out), .mgmt_interrupt_n_out(mgmt_interrupt_n_out),
	.device_monitor_summary_out(device_monitor_summary_out));

// ---- verification/host_io_model.sv ----
// Purpose: host side issuing observed I/O cycles
// Assumes: one cycle per call, launched just after a rising edge
// Notes: idle fields carry the inverse of the last cycle so stale values never look valid
`timescale 1ns/1ps
module host_io_model (
	input wire logic clk_in,
	output activity_monitor_pkg::io_cycle_s io_cycle_out
);
	initial io_cycle_out = '0;
	task automatic issue_typed(input logic [15:0] a, input logic [7:0] d, input logic [3:0] be,
			input logic [3:0] cmd);
		@(posedge clk_in);
		#1;
		io_cycle_out = '{1'b1, a, be, cmd, d};
		@(posedge clk_in);
		#1;
		io_cycle_out = '{1'b0, ~a, ~be, ~cmd, ~d};
	endtask : issue_typed
	// plain I/O write with byte enable field 4'he
	task automatic issue(input logic [15:0] a, input logic [7:0] d);
		issue_typed(a, d, 4'he, 4'h3);
	endtask : issue
endmodule : host_io_model

// ---- verification/tb.sv ----
// Purpose: self-checking bench for the legacy activity monitor
// Assumes: inputs change 1 ns after the rising edge
// Notes: range one covers 500h-50Fh, range two 600h-603h
`timescale 1ns/1ps
module tb;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic [3:0] pci_int_n_in = 4'hf;
	activity_monitor_pkg::range_cfg_s [1:0] rcfg = '{'{16'h0600, 16'h0004}, '{16'h0500, 16'h0010}};
	activity_monitor_pkg::reg_req_s req = '0;
	activity_monitor_pkg::io_cycle_s io;
	logic [15:0] rdata;
	logic rvalid;
	logic irq_n;
	logic summ;
	int mismatches = 0;
	int n_compared = 0;
	int cycles = 0;
	// {address, data, expected activity}
	logic [39:0] tab [23] = '{40'h0060_00_1000, 40'h0064_00_1000, 40'h0388_00_2000,
		40'h038b_00_2000, 40'h0330_00_0800, 40'h0331_00_0800, 40'h0220_00_0400,
		40'h0537_00_0400, 40'h0378_00_0020, 40'h03ff_00_0020, 40'h02f8_00_0020,
		40'h03f0_00_0020, 40'h03f7_00_0020, 40'h0050_00_0000, 40'h01f0_00_0001,
		40'h03f6_00_0001, 40'h0170_00_0004, 40'h0376_00_0004, 40'h01f6_10_0002,
		40'h01f7_00_0002, 40'h0176_10_0008, 40'h0376_00_0008, 40'h01f6_00_0001};
	always #12.5 clk_in = ~clk_in;
	host_io_model host_u (.clk_in(clk_in), .io_cycle_out(io));
	legacy_activity_smi_monitor dut_u (.clk_in(clk_in), .srst_in(srst_in), .io_cycle_in(io),
		.pci_int_n_in(pci_int_n_in), .range_cfg_in(rcfg), .reg_req_in(req),
		.reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .mgmt_interrupt_n_out(irq_n),
		.device_monitor_summary_out(summ));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic tick;
		@(posedge clk_in);
		#1;
	endtask : tick
	task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_bit(input logic got, input logic exp);
		chk_reg({15'h0, got}, {15'h0, exp});
	endtask : chk_bit
	task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
		tick();
		req = '{1'b0, 1'b1, a, be, d};
		tick();
		req = '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		tick();
		req = '{1'b1, 1'b0, a, 2'h3, 16'h0};
		tick();
		req = '0;
		chk_bit(rvalid, 1'b1);
		chk_reg(rdata, exp);
	endtask : rd
	task automatic finish_test;
		if (mismatches == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		chk_bit(irq_n, 1'b1);
		rd(8'h40, 16'h0000);
		wr(8'h4c, 2'h3, 16'hffff);
		rd(8'h4c, 16'h0000);
		rd(8'h50, 16'h0000);
	endtask : t_reset
	task automatic t_ranges;
		host_u.issue(16'h0500, 8'h00);
		chk_bit(irq_n, 1'b1);
		wr(8'h40, 2'h1, 16'h0300);
		rd(8'h40, 16'h0000);
		wr(8'h40, 2'h2, 16'h0100);
		host_u.issue(16'h0510, 8'h00);
		chk_bit(irq_n, 1'b1);
		host_u.issue(16'h050f, 8'h00);
		chk_bit(irq_n, 1'b0);
		rd(8'h40, 16'h1100);
		rd(8'h4c, 16'h050f);
		rd(8'h4e, 16'h00e3);
		chk_bit(irq_n, 1'b0);
		wr(8'h40, 2'h2, 16'h1300);
		chk_bit(irq_n, 1'b1);
		host_u.issue(16'h0603, 8'h00);
		rd(8'h40, 16'h2300);
		rd(8'h4c, 16'h0603);
		wr(8'h40, 2'h2, 16'h0300);
		rd(8'h40, 16'h2300);
		wr(8'h40, 2'h2, 16'h2000);
		rd(8'h40, 16'h0000);
		host_u.issue(16'h0600, 8'h00);
		chk_bit(irq_n, 1'b1);
	endtask : t_ranges
	task automatic t_activity;
		for (int i = 0; i < 23; i++) begin
			host_u.issue(tab[i][39:24], tab[i][23:16]);
			tick();
			chk_bit(summ, |(tab[i][15:0] & 16'h3000));
			wr(8'h44, 2'h3, 16'h0000);
			rd(8'h44, tab[i][15:0]);
			wr(8'h44, 2'h3, 16'hffff);
			rd(8'h44, 16'h0000);
		end
		// a read of the select port must not move the drive selection
		host_u.issue_typed(16'h01f6, 8'h10, 4'he, 4'h2);
		rd(8'h44, 16'h0001);
		wr(8'h44, 2'h3, 16'hffff);
		rd(8'h44, 16'h0000);
	endtask : t_activity
	task automatic t_pci;
		for (int i = 0; i < 4; i++) begin
			tick();
			pci_int_n_in = ~(4'h1 << i);
			rd(8'h44, 16'h0040 << i);
			pci_int_n_in = 4'hf;
			rd(8'h44, 16'h0040 << i);
			wr(8'h44, 2'h3, 16'h0040 << i);
			rd(8'h44, 16'h0000);
		end
	endtask : t_pci
	task automatic t_overlap;
		wr(8'h40, 2'h2, 16'h0100);
		host_u.issue_typed(16'h0501, 8'h00, 4'h7, 4'h2);
		// a hit and its clear in one cycle: the hit must win
		fork
			host_u.issue(16'h0502, 8'h00);
			wr(8'h40, 2'h2, 16'h1100);
		join
		chk_bit(irq_n, 1'b0);
		rd(8'h40, 16'h1100);
		rd(8'h4c, 16'h0501);
		rd(8'h4e, 16'h0072);
		host_u.issue(16'h0060, 8'h00);
		// reset in mid-run, held over three edges
		srst_in = 1'b1;
		repeat (3) tick();
		srst_in = 1'b0;
		chk_bit(irq_n, 1'b1);
		chk_bit(summ, 1'b0);
		rd(8'h40, 16'h0000);
		rd(8'h44, 16'h0000);
		rd(8'h4c, 16'h0000);
		rd(8'h4e, 16'h0000);
		host_u.issue(16'h0501, 8'h00);
		chk_bit(irq_n, 1'b1);
	endtask : t_overlap
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 4000) begin
			mismatches++;
			finish_test();
		end
	end
	initial begin
		repeat (12) @(posedge clk_in);
		#1;
		srst_in = 1'b0;
		t_reset();
		t_ranges();
		t_activity();
		t_pci();
		t_overlap();
		finish_test();
	end
endmodule : tb
